/* File: rtl/ost_defines.vh */
// ost_defines.vh - constants of the oscillator switch and autotrim block
// assumes a 100 MHz system clock and an APB register port
`ifndef OST_DEFINES_VH
`define OST_DEFINES_VH

// register byte offsets on the APB port
`define OST_CTRL_OFFSET 12'h000
`define OST_TRIM_OFFSET 12'h004

// control register field positions
`define OST_CUR_SRC_MSB 14
`define OST_CUR_SRC_LSB 12
`define OST_NEXT_SRC_MSB 10
`define OST_NEXT_SRC_LSB 8
`define OST_SEL_LOCK_BIT 7
`define OST_PIN_LOCK_BIT 6
`define OST_PLL_LOCK_BIT 5
`define OST_CLK_FAIL_BIT 3
`define OST_PRI_KEEP_BIT 2
`define OST_SEC_EN_BIT 1
`define OST_SWITCH_BIT 0

// trim register field positions
`define OST_TRIM_EN_BIT 15
`define OST_TRIM_REF_BIT 12
`define OST_TRIM_LOCKED_BIT 11
`define OST_TRIM_LPOL_BIT 10
`define OST_TRIM_RANGE_BIT 9
`define OST_TRIM_RPOL_BIT 8
`define OST_TRIM_VAL_MSB 5

// unlock keys for the high and low control bytes
`define OST_KEY_HI_FIRST 8'h78
`define OST_KEY_HI_SECOND 8'h9A
`define OST_KEY_LO_FIRST 8'h46
`define OST_KEY_LO_SECOND 8'h57

// clock source codes that run through the PLL
`define OST_SRC_FRC_PLL 3'h1
`define OST_SRC_PRI_PLL 3'h3

// timing in 100 MHz cycles: switch settle 1 us, PLL start-up 2 ms
`define OST_SETTLE_CYCLES 8'h64
`define OST_PLL_START_CYCLES 18'h30D40

// trim loop: expected fast RC edges per reference window
`define OST_SOF_EXPECT 17'h01F40
`define OST_SECONDARY_OSCILLATOR_EXPECT 17'h0F424
`define OST_SECONDARY_OSCILLATOR_WINDOW 8'hFF
// 0.2 percent and 1.5 percent of the expected counts
`define OST_SOF_LOCK_THR 17'h00010
`define OST_SECONDARY_OSCILLATOR_LOCK_THR 17'h0007D
`define OST_SOF_RANGE_THR 17'h00078
`define OST_SECONDARY_OSCILLATOR_RANGE_THR 17'h003A9
// trim value saturation limits (two's complement)
`define OST_TRIM_MAX 6'h1F
`define OST_TRIM_MIN 6'h20

`endif

/* File: rtl/ost_sync2.v */
// ost_sync2.v - two flip-flop synchroniser for asynchronous levels
// assumes inputs come from pins or other clocks; output is clk-domain
`timescale 1ns/1ps

module ost_sync2 #(
    parameter W = 1
) (
    input wire clk,            // system clock
    input wire rstn,           // synchronous reset, active low
    input wire [W-1:0] din,    // asynchronous inputs
    output reg [W-1:0] dout    // synchronised outputs
);

reg [W-1:0] stage1;

// first stage feeds only the second
always @(posedge clk) begin
    if (!rstn) begin
        stage1 <= {W{1'b0}};
        dout <= {W{1'b0}};
    end else begin
        stage1 <= din;
        dout <= stage1;
    end
end

endmodule // ost_sync2

/* File: rtl/ost_trim_loop.v */
// ost_trim_loop.v - automatic trim loop of the fast RC oscillator
// assumes edge pulses already synchronised to clk, one cycle each
`timescale 1ns/1ps
`include "ost_defines.vh"

module ost_trim_loop (
    input wire clk,            // system clock
    input wire rstn,           // synchronous reset, active low
    input wire enable,         // autotrim enable
    input wire refSel,         // 1 = usb frame start, 0 = secondary osc
    input wire frcEdge,        // one pulse per fast RC cycle
    input wire sofEdge,        // one pulse per usb start of frame
    input wire soscEdge,       // one pulse per secondary osc cycle
    input wire swWrite,        // software writes the trim value
    input wire [5:0] swData,   // trim value from software
    output reg [5:0] trimValue, // current trim value
    output reg lockedFlag,     // within 0.2 percent of reference
    output reg rangeFlag       // beyond 1.5 percent, out of range
);

reg started;
reg [7:0] winCnt;
reg [16:0] frcCount;
wire refEdge;
wire windowDone;
wire [16:0] expCount;
wire [16:0] lockThr;
wire [16:0] rangeThr;
wire fast;
wire [16:0] diff;

assign refEdge = refSel ? sofEdge : soscEdge;
assign windowDone = refEdge & (refSel | (winCnt == `OST_SECONDARY_OSCILLATOR_WINDOW));
assign expCount = refSel ? `OST_SOF_EXPECT : `OST_SECONDARY_OSCILLATOR_EXPECT;
assign lockThr = refSel ? `OST_SOF_LOCK_THR : `OST_SECONDARY_OSCILLATOR_LOCK_THR;
assign rangeThr = refSel ? `OST_SOF_RANGE_THR : `OST_SECONDARY_OSCILLATOR_RANGE_THR;
assign fast = frcCount > expCount;
assign diff = fast ? frcCount - expCount : expCount - frcCount;

// measure each window and step the trim one code toward the reference
always @(posedge clk) begin
    if (!rstn) begin
        started <= 1'b0;
        winCnt <= 8'h00;
        frcCount <= 17'h00000;
        trimValue <= 6'h00;
        lockedFlag <= 1'b0;
        rangeFlag <= 1'b0;
    end else if (!enable) begin
        started <= 1'b0;
        winCnt <= 8'h00;
        frcCount <= 17'h00000;
        lockedFlag <= 1'b0;
        rangeFlag <= 1'b0;
        if (swWrite)
            trimValue <= swData;
    end else if (!started) begin
        // first reference edge opens the first window
        if (refEdge)
            started <= 1'b1;
        winCnt <= 8'h00;
        frcCount <= 17'h00000;
    end else if (windowDone) begin
        winCnt <= 8'h00;
        frcCount <= 17'h00000;
        lockedFlag <= (diff <= lockThr);
        rangeFlag <= (diff > rangeThr);
        if (diff > lockThr) begin
            if (fast && trimValue != `OST_TRIM_MIN)
                trimValue <= trimValue - 6'h01;
            else if (!fast && trimValue != `OST_TRIM_MAX)
                trimValue <= trimValue + 6'h01;
        end
    end else begin
        if (refEdge)
            winCnt <= winCnt + 8'h01;
        if (frcEdge && frcCount != 17'h1FFFF)
            frcCount <= frcCount + 17'h00001;
    end
end

endmodule // ost_trim_loop

/* File: rtl/ost_osc_ctrl.v */
// ost_osc_ctrl.v - oscillator switch control with keyed unlock and
// automatic fast RC trim, reached over APB
// assumes a 100 MHz clk, straps stable from reset, pins asynchronous
//
// Summary of operation
// - monitor on and selection lock set: source and PLL selection refused
// - monitor off: selections never locked, whatever the lock bit holds
// - pin map lock changes only after unlock; one-way option blocks clear
// - PLL lock status is 1 when locked or start-up timer expired
// - PLL lock status clears during a switch and in non-PLL modes
// - clock failure flag set on detected failure while the monitor is on, else stays 0
// - primary keep bit holds primary oscillator running in sleep
// - secondary enable bit turns the 32 kHz oscillator on and off
// - switch request starts a switch to next source; clears when done
// - autotrim enable turns on calibration; reference chosen by select bit
// - select 1 uses usb frame starts, 0 uses the secondary oscillator
// - while calibrating, the six-bit trim value steps by one code, short of its limits, at the end of each reference window outside lock
// - software writes to the trim value are ignored while calibrating
// - lock within 0.2 and range beyond 1.5 percent shown as flags
// - polarity bits pick presence or absence of each trim condition
`timescale 1ns/1ps
`include "ost_defines.vh"

module ost_osc_ctrl #(
    parameter [17:0] PLL_START_CYCLES = `OST_PLL_START_CYCLES
) (
    input wire clk,                    // system clock, 100 MHz
    input wire rstn,                   // synchronous reset, active low
    input wire psel,                   // apb select
    input wire penable,                // apb access phase
    input wire pwrite,                 // apb write
    input wire [11:0] paddr,           // apb byte address
    input wire [31:0] pwdata,          // apb write data
    input wire [3:0] pstrb,            // apb byte strobes
    output wire pready,                // apb ready, always high
    output reg [31:0] prdata,          // apb read data
    output wire pslverr,               // apb error on unmapped address
    input wire failsafeMonitorCfg,     // strap: clock monitor enabled
    input wire pinMapOneWayCfg,        // strap: pin map lock one way
    input wire [2:0] initialSourceCfg, // strap: source after reset
    input wire sleepMode,              // core is in sleep
    input wire pllLockIn,              // pin: pll reports lock
    input wire clkFailIn,              // pin: monitor saw clock failure
    input wire usbSofIn,               // pin: usb start of frame level
    input wire soscClkIn,              // pin: secondary oscillator clock
    input wire frcClkIn,               // pin: fast rc oscillator clock
    output reg [2:0] currentSource,    // active clock source
    output wire pllEnable,             // pll must run
    output wire primaryOscEnable,      // primary oscillator runs
    output wire secondaryOscEnable,    // secondary oscillator runs
    output wire pinMapLock,            // pin mapping frozen
    output wire [5:0] trimValue,       // fast rc trim code
    output reg autotrimInterrupt       // one-cycle trim interrupt pulse
);

////////////////////////////////////////////////////////////////////////
// constants and state codes
localparam [1:0] SW_IDLE = 2'h0, SW_SETTLE = 2'h1, SW_PLL = 2'h2;
localparam [1:0] KEY_NONE = 2'h0, KEY_FIRST = 2'h1, KEY_OPEN = 2'h2;
localparam [7:0] SETTLE_CYCLES = `OST_SETTLE_CYCLES;

////////////////////////////////////////////////////////////////////////
// declarations
reg [2:0] nextSourceSelect;
reg selectionLock, pinMapLockBit, pllLockStatus, clockFailureFlag;
reg primaryOscSleepKeep, secondaryOscEnableBit, switchRequest;
reg autotrimEnable, autotrimReferenceSelect;
reg lockedFlagPolarity, rangeFlagPolarity, trimCondPrev;
reg [1:0] swState, hiKey, loKey;
reg [7:0] settleCnt;
reg [17:0] pllStartCnt;
reg [2:0] edgePrev;
wire [4:0] syncIn, syncOut;
wire pllLockSync, clkFailSync, frcEdge, sofEdge, soscEdge;
wire lockedFlag, rangeFlag, ctrlHit, trimHit, wrAccess, ctrlWr;
wire hiOnly, loOnly, loKeyWrite, selLocked, targetIsPll, pllActive;
wire pllStartDone, trimCond, trimSwWrite;
wire [7:0] hiData, loData;
wire [15:0] ctrlRead, trimRead;

////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge pulses
assign syncIn = {frcClkIn, soscClkIn, usbSofIn, clkFailIn, pllLockIn};

ost_sync2 #(.W(5)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din(syncIn),
    .dout(syncOut)
);

assign pllLockSync = syncOut[0];
assign clkFailSync = syncOut[1];

// rising edges of the three clock-like inputs
always @(posedge clk) begin
    if (!rstn)
        edgePrev <= 3'h0;
    else
        edgePrev <= syncOut[4:2];
end

assign sofEdge = syncOut[2] & ~edgePrev[0];
assign soscEdge = syncOut[3] & ~edgePrev[1];
assign frcEdge = syncOut[4] & ~edgePrev[2];

////////////////////////////////////////////////////////////////////////
// apb decode; single-cycle access, unmapped addresses answer error
assign ctrlHit = (paddr == `OST_CTRL_OFFSET);
assign trimHit = (paddr == `OST_TRIM_OFFSET);
assign pready = 1'b1;
assign pslverr = psel & penable & ~(ctrlHit | trimHit);
assign wrAccess = psel & penable & pwrite;
assign ctrlWr = wrAccess & ctrlHit;
assign hiOnly = (pstrb[1:0] == 2'b10);
assign loOnly = (pstrb[1:0] == 2'b01);
assign hiData = pwdata[15:8];
assign loData = pwdata[7:0];

// a low byte write consumed as an unlock key stores nothing
assign loKeyWrite = ctrlWr & loOnly & (loKey != KEY_OPEN) &
    ((loData == `OST_KEY_LO_FIRST) |
     (loKey == KEY_FIRST && loData == `OST_KEY_LO_SECOND));

////////////////////////////////////////////////////////////////////////
// unlock key trackers; any other write breaks the sequence
// ordered key pairs
always @(posedge clk) begin
    if (!rstn) begin
        hiKey <= KEY_NONE;
        loKey <= KEY_NONE;
    end else if (wrAccess) begin
        if (ctrlWr && hiOnly && hiData == `OST_KEY_HI_FIRST &&
            hiKey != KEY_OPEN)
            hiKey <= KEY_FIRST;
        else if (ctrlWr && hiOnly && hiData == `OST_KEY_HI_SECOND &&
            hiKey == KEY_FIRST)
            hiKey <= KEY_OPEN;
        else
            hiKey <= KEY_NONE;
        if (ctrlWr && loOnly && loData == `OST_KEY_LO_FIRST &&
            loKey != KEY_OPEN)
            loKey <= KEY_FIRST;
        else if (ctrlWr && loOnly && loData == `OST_KEY_LO_SECOND &&
            loKey == KEY_FIRST)
            loKey <= KEY_OPEN;
        else
            loKey <= KEY_NONE;
    end
end

////////////////////////////////////////////////////////////////////////
// selection lock and pll helpers
// lock honoured
assign selLocked = failsafeMonitorCfg & selectionLock;
assign targetIsPll = (nextSourceSelect == `OST_SRC_FRC_PLL) |
    (nextSourceSelect == `OST_SRC_PRI_PLL);
assign pllActive = (currentSource == `OST_SRC_FRC_PLL) |
    (currentSource == `OST_SRC_PRI_PLL);
assign pllStartDone = (pllStartCnt >= PLL_START_CYCLES);
assign pllEnable = pllActive | ((swState != SW_IDLE) & targetIsPll);

////////////////////////////////////////////////////////////////////////
// control register and clock switch sequencer
always @(posedge clk) begin
    if (!rstn) begin
        currentSource <= initialSourceCfg;
        nextSourceSelect <= initialSourceCfg;
        selectionLock <= 1'b0;
        pinMapLockBit <= 1'b0;
        clockFailureFlag <= 1'b0;
        primaryOscSleepKeep <= 1'b0;
        secondaryOscEnableBit <= 1'b0;
        switchRequest <= 1'b0;
        swState <= SW_IDLE;
        settleCnt <= 8'h00;
    end else begin
        // high byte: next source only in the open slot
        // high byte gate
        if (ctrlWr && pstrb[1] && hiKey == KEY_OPEN && !selLocked)
            nextSourceSelect <= pwdata[`OST_NEXT_SRC_MSB:`OST_NEXT_SRC_LSB];
        // low byte: free bits on any plain write, keyed bits when open
        if (ctrlWr && pstrb[0] && !loKeyWrite) begin
            selectionLock <= pwdata[`OST_SEL_LOCK_BIT];
            primaryOscSleepKeep <= pwdata[`OST_PRI_KEEP_BIT];
            secondaryOscEnableBit <= pwdata[`OST_SEC_EN_BIT];
            if (loKey == KEY_OPEN) begin
                if (pwdata[`OST_PIN_LOCK_BIT] || !pinMapOneWayCfg)
                    pinMapLockBit <= pwdata[`OST_PIN_LOCK_BIT];
            end
        end
        if (failsafeMonitorCfg && clkFailSync)
            clockFailureFlag <= 1'b1;
        else if (ctrlWr && pstrb[0] && !loKeyWrite &&
                 !pwdata[`OST_CLK_FAIL_BIT])
            clockFailureFlag <= 1'b0;
        case (swState)
            SW_IDLE: begin
                settleCnt <= 8'h00;
                if (ctrlWr && pstrb[0] && loKey == KEY_OPEN &&
                    !selLocked && pwdata[`OST_SWITCH_BIT]) begin
                    switchRequest <= 1'b1;
                    swState <= SW_SETTLE;
                end
            end
            SW_SETTLE: begin
                if (settleCnt >= SETTLE_CYCLES - 8'h01) begin
                    settleCnt <= 8'h00;
                    if (targetIsPll) begin
                        swState <= SW_PLL;
                    end else begin
                        currentSource <= nextSourceSelect;
                        switchRequest <= 1'b0;
                        swState <= SW_IDLE;
                    end
                end else begin
                    settleCnt <= settleCnt + 8'h01;
                end
            end
            SW_PLL: begin
                // without pll lock the request stays set as a failure
                if (pllLockSync) begin
                    currentSource <= nextSourceSelect;
                    switchRequest <= 1'b0;
                    swState <= SW_IDLE;
                end else if (ctrlWr && pstrb[0] && loKey == KEY_OPEN &&
                             !pwdata[`OST_SWITCH_BIT]) begin
                    // software abandons a switch that never locked
                    switchRequest <= 1'b0;
                    swState <= SW_IDLE;
                end
            end
            default: begin
                switchRequest <= 1'b0;
                swState <= SW_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// pll start-up timer and lock status
always @(posedge clk) begin
    if (!rstn) begin
        pllStartCnt <= 18'h00000;
        pllLockStatus <= 1'b0;
    end else begin
        if (pllActive && swState == SW_IDLE) begin
            if (!pllStartDone)
                pllStartCnt <= pllStartCnt + 18'h00001;
        end else begin
            pllStartCnt <= 18'h00000;
        end
        pllLockStatus <= pllActive & (swState == SW_IDLE) &
            (pllLockSync | pllStartDone);
    end
end

////////////////////////////////////////////////////////////////////////
// trim control register and trim loop
always @(posedge clk) begin
    if (!rstn) begin
        autotrimEnable <= 1'b0;
        autotrimReferenceSelect <= 1'b0;
        lockedFlagPolarity <= 1'b0;
        rangeFlagPolarity <= 1'b0;
    end else if (wrAccess && trimHit) begin
        if (pstrb[1]) begin
            autotrimEnable <= pwdata[`OST_TRIM_EN_BIT];
            autotrimReferenceSelect <= pwdata[`OST_TRIM_REF_BIT];
            lockedFlagPolarity <= pwdata[`OST_TRIM_LPOL_BIT];
            rangeFlagPolarity <= pwdata[`OST_TRIM_RPOL_BIT];
        end
    end
end

assign trimSwWrite = wrAccess & trimHit & pstrb[0] & ~autotrimEnable;

ost_trim_loop u_trim (
    .clk(clk),
    .rstn(rstn),
    .enable(autotrimEnable),
    .refSel(autotrimReferenceSelect),
    .frcEdge(frcEdge),
    .sofEdge(sofEdge),
    .soscEdge(soscEdge),
    .swWrite(trimSwWrite),
    .swData(pwdata[`OST_TRIM_VAL_MSB:0]),
    .trimValue(trimValue),
    .lockedFlag(lockedFlag),
    .rangeFlag(rangeFlag)
);

assign trimCond = autotrimEnable &
    ((lockedFlagPolarity ? lockedFlag : ~lockedFlag) |
     (rangeFlagPolarity ? rangeFlag : ~rangeFlag));

// interrupt pulses once as the selected condition appears
always @(posedge clk) begin
    if (!rstn) begin
        trimCondPrev <= 1'b0;
        autotrimInterrupt <= 1'b0;
    end else begin
        trimCondPrev <= trimCond;
        autotrimInterrupt <= trimCond & ~trimCondPrev;
    end
end

////////////////////////////////////////////////////////////////////////
// outputs and read data
// primary in sleep
assign primaryOscEnable = primaryOscSleepKeep | ~sleepMode;
assign secondaryOscEnable = secondaryOscEnableBit;
assign pinMapLock = pinMapLockBit;

assign ctrlRead = {1'b0, currentSource, 1'b0, nextSourceSelect,
    selectionLock, pinMapLockBit, pllLockStatus, 1'b0,
    clockFailureFlag, primaryOscSleepKeep, secondaryOscEnableBit,
    switchRequest};
assign trimRead = {autotrimEnable, 2'b00, autotrimReferenceSelect,
    lockedFlag, lockedFlagPolarity, rangeFlag, rangeFlagPolarity,
    2'b00, trimValue};

// read data captured in the setup phase, shown in the access phase
always @(posedge clk) begin
    if (!rstn)
        prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite) begin
        if (paddr == `OST_CTRL_OFFSET)
            prdata <= {16'h0000, ctrlRead};
        else if (paddr == `OST_TRIM_OFFSET)
            prdata <= {16'h0000, trimRead};
        else
            prdata <= 32'h00000000;
    end
end

endmodule // ost_osc_ctrl

/* File: testbench/ost_osc_ctrl_sva.sv */
// checker of port relations of the oscillator control block
// assumes it is bound onto ost_osc_ctrl, one clock domain
`timescale 1ns/1ps

module ost_osc_ctrl_sva (
    input logic clk, // system clock
    input logic rstn, // synchronous reset, low
    input logic psel, // apb select
    input logic penable, // apb access phase
    input logic pwrite, // apb write
    input logic [11:0] paddr, // apb address
    input logic [31:0] pwdata, // apb write data
    input logic [3:0] pstrb, // apb strobes
    input logic pready, // apb ready
    input logic [31:0] prdata, // apb read data
    input logic pslverr, // apb error
    input logic pinMapOneWayCfg, // one-way strap
    input logic sleepMode, // core asleep
    input logic primaryOscEnable, // primary runs
    input logic secondaryOscEnable, // secondary runs
    input logic pinMapLock, // pin map frozen
    input logic [5:0] trimValue, // trim code
    input logic autotrimInterrupt // trim interrupt
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);

////////////////////////////////////////////////////////////////////////////
// completed writes: control register low byte, trim register any byte
wire ctlWr = psel && penable && pwrite && pstrb[0] && paddr == 12'h000;
wire trimWr = psel && penable && pwrite && paddr == 12'h004;

////////////////////////////////////////////////////////////////////////////
// bus answers
a_ready_always: assert property (pready)
    else $error("pready low");
a_slverr_map: assert property (pslverr == (psel && penable
    && paddr != 12'h000 && paddr != 12'h004))
    else $error("pslverr wrong");
a_upper_zero: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
// oscillator enables
a_prim_awake: assert property (!sleepMode |-> primaryOscEnable)
    else $error("primary off while awake");
a_sec_follow: assert property (!$stable(secondaryOscEnable) |->
    $past(ctlWr) && secondaryOscEnable == $past(pwdata[1]))
    else $error("secondary enable moved without write");
// pin map lock
a_pin_set_write: assert property ($rose(pinMapLock) |->
    $past(ctlWr && pwdata[6]))
    else $error("pin lock set without write");
a_pin_one_way: assert property (pinMapOneWayCfg && $past(pinMapLock)
    |-> pinMapLock)
    else $error("one-way pin lock cleared");
// trim loop steps and interrupt pulse
a_trim_step: assert property (!$stable(trimValue) && !$past(trimWr) |->
    trimValue - $past(trimValue) inside {6'h01, 6'h3F})
    else $error("trim moved by more than one");
a_irq_pulse: assert property (autotrimInterrupt |=> !autotrimInterrupt)
    else $error("trim interrupt longer than one cycle");
endmodule // ost_osc_ctrl_sva

bind ost_osc_ctrl ost_osc_ctrl_sva u_sva (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pinMapOneWayCfg(pinMapOneWayCfg),
    .sleepMode(sleepMode), .primaryOscEnable(primaryOscEnable),
    .secondaryOscEnable(secondaryOscEnable), .pinMapLock(pinMapLock),
    .trimValue(trimValue), .autotrimInterrupt(autotrimInterrupt));

/* File: testbench/tb.sv */
// self-checking bench of the oscillator control block
// assumes apb register access and a short pll start time
`timescale 1ns/1ps

module tb;
logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, rd;
logic [3:0] pstrb;
logic fsm, oneWay, sleepMode, pllLock, clkFail, tie0, sof, fast_rc_oscillator;
logic [2:0] curSrc;
logic pllEn, primEn, secEn, pinLock, irq;
logic [5:0] trim;
integer num_errors = 0;
integer compares = 0;
integer cyc = 0;
integer irqs = 0;

////////////////////////////////////////////////////////////////////////////
ost_osc_ctrl #(.PLL_START_CYCLES(18'h00032)) u_ost_osc_ctrl (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .failsafeMonitorCfg(fsm), .pinMapOneWayCfg(oneWay),
    .initialSourceCfg(3'h2), .sleepMode(sleepMode), .pllLockIn(pllLock),
    .clkFailIn(clkFail), .usbSofIn(sof), .soscClkIn(tie0),
    .frcClkIn(fast_rc_oscillator), .currentSource(curSrc), .pllEnable(pllEn),
    .primaryOscEnable(primEn), .secondaryOscEnable(secEn),
    .pinMapLock(pinLock), .trimValue(trim), .autotrimInterrupt(irq));

// clock, fast rc stand-in, interrupt count and hang guard
initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cyc <= cyc + 1;
    fast_rc_oscillator <= ~fast_rc_oscillator;
    if (irq === 1'b1)
        irqs <= irqs + 1;
    if (cyc == 20000) begin
        num_errors = num_errors + 1;
        give_verdict;
    end
end

////////////////////////////////////////////////////////////////////////////
task give_verdict;
    begin
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
endtask
task chk(input [31:0] seen, input [31:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
// one apb transfer, held until pready is sampled high
task apb(input [11:0] a, input w, input [31:0] d, input [3:0] s);
    begin
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    end
endtask
task rdc;
    apb(12'h000, 1'b0, 32'h0, 4'h0);
endtask
task wrc(input [15:0] d, input [3:0] s);
    apb(12'h000, 1'b1, {16'h0, d}, s);
endtask
// key pair written to both lanes, strobe picks the byte
task key(input [7:0] a, input [7:0] b, input [3:0] s);
    begin
        wrc({a, a}, s);
        wrc({b, b}, s);
    end
endtask
// full switch sequence, then poll the request bit
task sw(input [2:0] src, input [7:0] lo);
    integer k;
    begin
        key(8'h78, 8'h9A, 4'h2);
        wrc({5'h0, src, 8'h00}, 4'h2);
        key(8'h46, 8'h57, 4'h1);
        wrc({8'h0, lo}, 4'h1);
        for (k = 0; k < 80 && (k == 0 || rd[0]); k = k + 1)
            rdc;
    end
endtask

////////////////////////////////////////////////////////////////////////////
// main sequence
initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    fsm = 1'b0;
    oneWay = 1'b0;
    sleepMode = 1'b0;
    pllLock = 1'b0;
    clkFail = 1'b0;
    tie0 = 1'b0;
    sof = 1'b0;
    fast_rc_oscillator = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc;
    chk(rd, 32'h00002200);
    wrc(16'h0500, 4'h2);
    rdc;
    chk(rd, 32'h00002200);
    apb(12'h008, 1'b0, 32'h0, 4'h0);
    chk(err, 1'h1);
    chk(rd, 32'h0);
    $display("test reset and refusal done");
    sw(3'h4, 8'h03);
    chk(rd, 32'h00004402);
    chk(secEn, 1'h1);
    fsm <= 1'b1;
    wrc(16'h0082, 4'h1);
    sw(3'h2, 8'h83);
    chk(rd, 32'h00004482);
    fsm <= 1'b0;
    pllLock <= 1'b1;
    sw(3'h1, 8'h83);
    chk(rd, 32'h000011A2);
    chk(pllEn, 1'h1);
    sw(3'h4, 8'h83);
    chk(rd, 32'h00004482);
    $display("test clock switch done");
    wrc(16'h00C2, 4'h1);
    chk(pinLock, 1'h0);
    key(8'h46, 8'h57, 4'h1);
    wrc(16'h00C2, 4'h1);
    chk(pinLock, 1'h1);
    oneWay <= 1'b1;
    key(8'h46, 8'h57, 4'h1);
    wrc(16'h0082, 4'h1);
    chk(pinLock, 1'h1);
    fsm <= 1'b1;
    clkFail <= 1'b1;
    repeat (4) @(posedge clk);
    rdc;
    chk(rd[3], 1'h1);
    sleepMode <= 1'b1;
    repeat (2) @(posedge clk);
    chk(primEn, 1'h0);
    wrc(16'h0086, 4'h1);
    chk(primEn, 1'h1);
    $display("test lock and status done");
    apb(12'h004, 1'b1, 32'h00000005, 4'h3);
    chk(trim, 6'h05);
    apb(12'h004, 1'b1, 32'h00009500, 4'h2);
    apb(12'h004, 1'b1, 32'h0000950A, 4'h3);
    chk(trim, 6'h05);
    repeat (3) begin
        sof <= 1'b1;
        @(posedge clk);
        sof <= 1'b0;
        repeat (200) @(posedge clk);
    end
    apb(12'h004, 1'b0, 32'h0, 4'h0);
    chk(rd[15:0], 16'h9707);
    chk(trim, 6'h07);
    chk(irqs, 1);
    $display("test trim done");
    give_verdict;
end
endmodule // tb
